/* File: rtl/adc_output_path.sv */
// serial configuration registers and digital output path of the sampling converter
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

module adc_output_path (
  // clock and reset
  input  wire logic                            i_core_clk,
  input  wire logic                            i_rst,
  // serial configuration pins
  input  wire adc_cfg_pkg::serial_pins_type    i_serial,
  // straps
  input  wire logic                            i_format_strap,
  input  wire logic                            i_interface_strap,
  // converter samples, offset binary
  input  wire logic [11:0]                     i_sample,
  // output word and clock pins
  output logic      [11:0]                     o_data,
  output logic                                 o_data_oe,
  output logic                                 o_output_clock,
  output logic                                 o_clock_oe,
  // stored analog settings
  output adc_cfg_pkg::analog_cfg_type          o_analog
);
  import adc_cfg_pkg::*;

  function automatic logic [11:0] gain_coef(input logic [3:0] g);
    unique case (g)
      4'h0: gain_coef = 12'h400;
      4'h1: gain_coef = 12'h43D;
      4'h2: gain_coef = 12'h47D;
      4'h3: gain_coef = 12'h4C1;
      4'h4: gain_coef = 12'h509;
      4'h5: gain_coef = 12'h556;
      4'h6: gain_coef = 12'h5A6;
      4'h7: gain_coef = 12'h5FC;
      4'h8: gain_coef = 12'h657;
      4'h9: gain_coef = 12'h6B7;
      4'hA: gain_coef = 12'h71D;
      4'hB: gain_coef = 12'h789;
      default: gain_coef = 12'h7FB;
    endcase
  endfunction

  function automatic logic [11:0] sat12(input logic signed [27:0] v);
    if (v < 28'sh0) begin
      sat12 = 12'h000;
    end else if (v > 28'sh0000FFF) begin
      sat12 = 12'hFFF;
    end else begin
      sat12 = v[11:0];
    end
  endfunction

  // pin synchronisers; the first stage feeds only the second
  logic sen_s1, sen_s2, sclk_s1, sclk_s2, sclk_s3, sdata_s1, sdata_s2;
  logic fstrap_s1, fstrap_s2, istrap_s1, istrap_s2;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sen_s1    <= 1'b1;
      sen_s2    <= 1'b1;
      sclk_s1   <= 1'b0;
      sclk_s2   <= 1'b0;
      sclk_s3   <= 1'b0;
      sdata_s1  <= 1'b0;
      sdata_s2  <= 1'b0;
      fstrap_s1 <= 1'b0;
      fstrap_s2 <= 1'b0;
      istrap_s1 <= 1'b0;
      istrap_s2 <= 1'b0;
    end else begin
      sen_s1    <= i_serial.sen_n;
      sen_s2    <= sen_s1;
      sclk_s1   <= i_serial.sclk;
      sclk_s2   <= sclk_s1;
      sclk_s3   <= sclk_s2;
      sdata_s1  <= i_serial.sdata;
      sdata_s2  <= sdata_s1;
      fstrap_s1 <= i_format_strap;
      fstrap_s2 <= fstrap_s1;
      istrap_s1 <= i_interface_strap;
      istrap_s2 <= istrap_s1;
    end
  end

  // serial receiver: 8 address bits then 8 data bits, msb first, taken on clock rise
  link_state_type state, next_state;
  logic [3:0]     bit_cnt, next_bit_cnt;
  logic [14:0]    shreg, next_shreg;
  logic           sclk_rise, wr_en;
  logic [7:0]     wr_addr, wr_data;

  always_comb begin
    sclk_rise    = sclk_s2 & ~sclk_s3;
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    wr_en        = 1'b0;
    wr_addr      = shreg[14:7];
    wr_data      = {shreg[6:0], sdata_s2};
    if (sen_s2) begin
      next_state   = link_idle;
      next_bit_cnt = 4'h0;
    end else begin
      next_state = link_shift;
      if (sclk_rise) begin
        next_shreg   = {shreg[13:0], sdata_s2};
        next_bit_cnt = 4'(bit_cnt + 4'h1);
        wr_en        = (bit_cnt == `FRAME_LAST_BIT);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state   <= link_idle;
      bit_cnt <= 4'h0;
      shreg   <= 15'h0000;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
    end
  end

  // configuration registers; reserved bits are forced to zero on write
  cfg_type cfg, next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (wr_en) begin
      unique case (wr_addr)
        // soft reset restores defaults, bit never stored
        `REG_CONTROL:      if (wr_data[`SOFT_RESET_BIT]) next_cfg = {12{`CFG_RESET_BYTE}};
        `REG_PERF_ONE:     next_cfg.perf_one = wr_data & `MASK_PERF_ONE;
        `REG_GAIN_PATTERN: next_cfg.gain_pattern = wr_data;
        `REG_DRIVE:        next_cfg.drive = wr_data & `MASK_DRIVE;
        `REG_FORMAT:       next_cfg.format = wr_data & `MASK_FORMAT;
        `REG_USER_HIGH:    next_cfg.user_high = wr_data;
        `REG_USER_LOW:     next_cfg.user_low = wr_data & `MASK_USER_LOW;
        `REG_IFACE_RISE:   next_cfg.iface_rise = wr_data;
        `REG_FALL_LATENCY: next_cfg.fall_lat = wr_data & `MASK_FALL_LATENCY;
        `REG_POWER:        next_cfg.power = wr_data & `MASK_POWER;
        `REG_PERF_TWO:     next_cfg.perf_two = wr_data & `MASK_PERF_TWO;
        `REG_BIAS:         next_cfg.bias = wr_data & `MASK_BIAS;
        `REG_TRIM_CTRL:    next_cfg.trim_ctrl = wr_data & `MASK_TRIM_CTRL;
        default:           next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg <= {12{`CFG_RESET_BYTE}};
    end else begin
      cfg <= next_cfg;
    end
  end

  // data path; one output word every two clocks
  logic                digital_on, trim_on, trim_hold, gain_on, buffers_off, twos, strobe;
  logic                phase, next_phase, toggle, next_toggle, clk_out, next_clk_out;
  logic [1:0]          ramp_div, next_ramp_div;
  logic [11:0]         ramp, next_ramp, corrected, gained, word, next_data;
  logic [3:0]          window;
  logic [5:0]          shift;
  logic signed [13:0]  target, dev;
  logic signed [47:0]  acc, next_acc, dev_wide;
  logic signed [12:0]  centered;
  logic signed [25:0]  product;
  analog_cfg_type      next_analog;

  always_comb begin
    strobe      = phase;
    digital_on  = cfg.fall_lat[`DIGITAL_ENABLE_BIT];
    buffers_off = cfg.power[`DRIVER_OFF_BIT] | cfg.power[`FULL_SLEEP_BIT] | cfg.fall_lat[`QUICK_SLEEP_BIT];
    trim_on     = digital_on & cfg.format[`TRIM_ENABLE_BIT];
    trim_hold   = cfg.trim_ctrl[`TRIM_HOLD_BIT];
    // target is mid-code plus signed bias
    target      = $signed({2'b00, `MID_CODE}) + 14'(signed'(cfg.bias[`BIAS_FIELD]));
    dev         = $signed({2'b00, i_sample}) - target;
    dev_wide    = 48'(signed'(dev)) <<< 32;
    // window 2^(20+code) clocks, codes above 1011 clamp
    window      = (cfg.trim_ctrl[`TRIM_WINDOW_FIELD] > `TRIM_MAX_CODE) ? `TRIM_MAX_CODE
                                                                        : cfg.trim_ctrl[`TRIM_WINDOW_FIELD];
    shift       = `TRIM_BASE_SHIFT + {2'b00, window};
    if (!trim_on) begin
      next_acc = 48'sh0;
    end else if (trim_hold) begin
      next_acc = acc;
    end else begin
      next_acc = acc + ((dev_wide - acc) >>> shift);
    end
    corrected = trim_on ? sat12(28'(signed'({6'b000000, i_sample})) - 28'(signed'(acc[47:32]))) : i_sample;
    // bypass bit or low latency skips gain
    gain_on   = digital_on & ~cfg.gain_pattern[`GAIN_BYPASS_BIT];
    centered  = $signed({1'b0, corrected}) - $signed({1'b0, `MID_CODE});
    product   = centered * $signed({1'b0, gain_coef(cfg.gain_pattern[`GAIN_FIELD])});
    gained    = gain_on ? sat12(28'(product >>> 10) + 28'(signed'({1'b0, `MID_CODE}))) : corrected;
    word = gained;
    if (digital_on) begin
      unique case (cfg.gain_pattern[`PATTERN_FIELD])
        `PAT_ZEROS:  word = 12'h000;
        `PAT_ONES:   word = 12'hFFF;
        `PAT_TOGGLE: word = toggle ? ~`TOGGLE_WORD : `TOGGLE_WORD;
        `PAT_RAMP:   word = ramp;
        `PAT_USER:   word = {cfg.user_high, cfg.user_low[`USER_LOW_FIELD]};
        default:     word = gained;
      endcase
    end
    // format coding last; twos complement flips the msb
    unique case (cfg.format[`FORMAT_FIELD])
      `FMT_TWOS:   twos = 1'b1;
      `FMT_OFFSET: twos = 1'b0;
      default:     twos = fstrap_s2;
    endcase
    next_data     = buffers_off ? 12'h000 : (strobe ? {word[11] ^ twos, word[10:0]} : o_data);
    next_phase    = ~phase;
    next_toggle   = strobe ? ~toggle : toggle;
    next_ramp_div = 2'(ramp_div + 2'h1);
    next_ramp     = (ramp_div == `RAMP_DIV_LAST) ? 12'(ramp + 12'h001) : ramp;
    // interface select, strap 0 means double data rate
    unique case (cfg.iface_rise[`IFACE_FIELD])
      `IF_DDR:      next_analog.ddr_mode = 1'b1;
      `IF_PARALLEL: next_analog.ddr_mode = 1'b0;
      default:      next_analog.ddr_mode = ~istrap_s2;
    endcase
    // in double data rate mode aligned rise follows the data change, otherwise rise is mid-word
    if (cfg.iface_rise[`RISE_ENABLE_BIT] && cfg.iface_rise[`RISE_AMOUNT_FIELD] == `RISE_ALIGN
        && next_analog.ddr_mode) begin
      next_clk_out = ~next_phase;
    end else begin
      next_clk_out = next_phase;
    end
    // pins released while buffers are down
    if (buffers_off) begin
      next_clk_out = 1'b0;
    end
    next_analog.perf_boost_a             = (cfg.perf_one[`PERF_ONE_FIELD] == `FIELD_ON);
    next_analog.perf_boost_b             = cfg.perf_two[`PERF_TWO_BIT];
    next_analog.clock_driver_drive       = cfg.drive[`CLOCK_DRIVE_BIT];
    next_analog.data_driver_drive        = cfg.drive[`DATA_DRIVE_BIT];
    next_analog.single_ended_clock_drive = cfg.iface_rise[`SE_CLOCK_DRIVE_FIELD];
    next_analog.swing_override           = (cfg.power[`SWING_FIELD] == `FIELD_ON);
    next_analog.rise_shift_enable        = cfg.iface_rise[`RISE_ENABLE_BIT];
    next_analog.rise_shift_amount        = cfg.iface_rise[`RISE_AMOUNT_FIELD];
    // fall shift handed to the clock buffer
    next_analog.fall_shift_enable        = cfg.iface_rise[`FALL_ENABLE_BIT];
    next_analog.fall_shift_amount        = cfg.fall_lat[`FALL_AMOUNT_FIELD];
    next_analog.quick_sleep              = cfg.fall_lat[`QUICK_SLEEP_BIT];
    next_analog.full_sleep               = cfg.power[`FULL_SLEEP_BIT];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acc            <= 48'sh0;
      phase          <= 1'b0;
      toggle         <= 1'b0;
      ramp_div       <= 2'h0;
      ramp           <= 12'h000;
      o_data         <= 12'h000;
      o_data_oe      <= 1'b0;
      o_clock_oe     <= 1'b0;
      o_output_clock <= 1'b0;
      o_analog       <= '0;
    end else begin
      acc            <= next_acc;
      phase          <= next_phase;
      toggle         <= next_toggle;
      ramp_div       <= next_ramp_div;
      ramp           <= next_ramp;
      o_data         <= next_data;
      o_data_oe      <= ~buffers_off;
      o_clock_oe     <= ~buffers_off;
      o_output_clock <= next_clk_out;
      o_analog       <= next_analog;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_soft_reset_clear:
    assert property (wr_en && wr_addr == `REG_CONTROL && wr_data[`SOFT_RESET_BIT] |=> cfg == '0)
      else $error("soft reset did not restore registers");
  a_user_low_zero:
    assert property (cfg.user_low[3:0] == 4'h0)
      else $error("user word low nibble not zero");
  a_zero_pattern:
    assert property (strobe && !buffers_off && digital_on && cfg.gain_pattern[2:0] == `PAT_ZEROS
                     && !twos |=> o_data == 12'h000)
      else $error("zero pattern wrong");
  a_toggle_words:
    assert property ((strobe && !buffers_off && digital_on && cfg.gain_pattern[2:0] == `PAT_TOGGLE) ##2
                     (strobe && !buffers_off && digital_on && cfg.gain_pattern[2:0] == `PAT_TOGGLE
                     && $stable(cfg)) |=> o_data == ~$past(o_data, 2))
      else $error("toggle words not complementary");
  a_ramp_step:
    assert property (ramp_div == `RAMP_DIV_LAST |=> ramp == 12'($past(ramp) + 12'h001) ##1 $stable(ramp)[*3])
      else $error("ramp step timing wrong");
  a_low_latency_pass:
    assert property (strobe && !buffers_off && !digital_on && !twos
                     |=> o_data == $past(i_sample))
      else $error("low latency path altered sample");
  a_driver_off:
    assert property (cfg.power[`DRIVER_OFF_BIT] |=> !o_data_oe && !o_clock_oe && o_data == 12'h000)
      else $error("pins driven while buffers off");
  a_trim_disabled:
    assert property (!trim_on |=> acc == 48'sh0)
      else $error("trim estimate kept while disabled");
  a_trim_hold:
    assert property (trim_on && trim_hold ##1 trim_on && trim_hold |-> $stable(acc))
      else $error("held trim estimate moved");
  a_rise_align:
    assert property (!buffers_off && o_analog.ddr_mode && o_analog.rise_shift_enable
                     && o_analog.rise_shift_amount == `RISE_ALIGN && $stable(o_analog) && $stable(buffers_off)
                     |-> o_output_clock == ~phase)
      else $error("aligned rise not on data change");

  c_frame_write:  cover property (wr_en && state == link_shift);
  c_ramp_out:     cover property (digital_on && cfg.gain_pattern[2:0] == `PAT_RAMP && strobe);
  c_trim_hold:    cover property (trim_on && trim_hold);
  c_buffers_down: cover property ($rose(buffers_off));
endmodule

/* File: rtl/adc_cfg_defines.svh */
// offsets, field positions, codes, reset values and counts for the converter output path
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH
`define REG_CONTROL          8'h00
`define REG_PERF_ONE         8'h03
`define REG_GAIN_PATTERN     8'h25
`define REG_DRIVE            8'h26
`define REG_FORMAT           8'h3D
`define REG_USER_HIGH        8'h3F
`define REG_USER_LOW         8'h40
`define REG_IFACE_RISE       8'h41
`define REG_FALL_LATENCY     8'h42
`define REG_POWER            8'h43
`define REG_PERF_TWO         8'h4A
`define REG_BIAS             8'hBF
`define REG_TRIM_CTRL        8'hCF
`define MASK_PERF_ONE        8'h03
`define MASK_DRIVE           8'h03
`define MASK_FORMAT          8'hE0
`define MASK_USER_LOW        8'hF0
`define MASK_FALL_LATENCY    8'hCC
`define MASK_POWER           8'h53
`define MASK_PERF_TWO        8'h01
`define MASK_BIAS            8'hF0
`define MASK_TRIM_CTRL       8'hBC
`define CFG_RESET_BYTE       8'h00
`define SOFT_RESET_BIT       1
`define PERF_ONE_FIELD       1:0
`define GAIN_FIELD           7:4
`define GAIN_BYPASS_BIT      3
`define PATTERN_FIELD        2:0
`define CLOCK_DRIVE_BIT      1
`define DATA_DRIVE_BIT       0
`define FORMAT_FIELD         7:6
`define TRIM_ENABLE_BIT      5
`define USER_LOW_FIELD       7:4
`define IFACE_FIELD          7:6
`define SE_CLOCK_DRIVE_FIELD 5:4
`define RISE_ENABLE_BIT      3
`define RISE_AMOUNT_FIELD    2:1
`define FALL_ENABLE_BIT      0
`define FALL_AMOUNT_FIELD    7:6
`define DIGITAL_ENABLE_BIT   3
`define QUICK_SLEEP_BIT      2
`define FULL_SLEEP_BIT       6
`define DRIVER_OFF_BIT       4
`define SWING_FIELD          1:0
`define PERF_TWO_BIT         0
`define BIAS_FIELD           7:4
`define TRIM_HOLD_BIT        7
`define TRIM_WINDOW_FIELD    5:2
`define PAT_SAMPLES          3'h0
`define PAT_ZEROS            3'h1
`define PAT_ONES             3'h2
`define PAT_TOGGLE           3'h3
`define PAT_RAMP             3'h4
`define PAT_USER             3'h5
`define FMT_TWOS             2'h2
`define FMT_OFFSET           2'h3
`define IF_DDR               2'h1
`define IF_PARALLEL          2'h3
`define FIELD_ON             2'h3
`define RISE_ALIGN           2'h2
`define TOGGLE_WORD          12'h555
`define MID_CODE             12'h800
`define TRIM_BASE_SHIFT      6'h14
`define TRIM_MAX_CODE        4'hB
`define RAMP_DIV_LAST        2'h3
`define FRAME_LAST_BIT       4'hF
`endif

/* File: rtl/adc_cfg_pkg.sv */
// types shared by the converter output path
package adc_cfg_pkg;
  typedef struct packed {
    logic sen_n;
    logic sclk;
    logic sdata;
  } serial_pins_type;

  typedef struct packed {
    logic [7:0] perf_one;
    logic [7:0] gain_pattern;
    logic [7:0] drive;
    logic [7:0] format;
    logic [7:0] user_high;
    logic [7:0] user_low;
    logic [7:0] iface_rise;
    logic [7:0] fall_lat;
    logic [7:0] power;
    logic [7:0] perf_two;
    logic [7:0] bias;
    logic [7:0] trim_ctrl;
  } cfg_type;

  typedef struct packed {
    logic       perf_boost_a;
    logic       perf_boost_b;
    logic       clock_driver_drive;
    logic       data_driver_drive;
    logic [1:0] single_ended_clock_drive;
    logic       swing_override;
    logic       rise_shift_enable;
    logic [1:0] rise_shift_amount;
    logic       fall_shift_enable;
    logic [1:0] fall_shift_amount;
    logic       ddr_mode;
    logic       quick_sleep;
    logic       full_sleep;
  } analog_cfg_type;

  typedef enum logic {link_idle, link_shift} link_state_type;
endpackage

/* File: verification/capture_model.sv */
// capture-side model: takes one output word at each rise of the output clock
`timescale 1ns/1ps
module capture_model (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // pins from the converter
  input  wire logic [11:0] i_data,
  input  wire logic        i_data_oe,
  input  wire logic        i_output_clock,
  input  wire logic        i_clock_oe,
  // captured word
  output logic      [11:0] o_word,
  output logic             o_word_valid
);
  logic        last_clock;
  logic [11:0] pin_data;
  logic        pin_clock;
  // released pins float: show the complement of the last word, never a stale copy
  assign pin_data  = i_data_oe ? i_data : ~o_word;
  assign pin_clock = i_clock_oe & i_output_clock;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      last_clock   <= 1'b0;
      o_word_valid <= 1'b0;
      o_word       <= 12'h000;
    end else begin
      last_clock   <= pin_clock;
      o_word_valid <= pin_clock & ~last_clock;
      if (pin_clock & ~last_clock) begin
        o_word <= pin_data;
      end
    end
  end
endmodule

/* File: verification/adc_output_path_bench.sv */
// self-checking bench for the converter output path
`timescale 1ns/1ps
module adc_output_path_bench;
  import adc_cfg_pkg::*;
  logic            i_core_clk, i_rst, i_format_strap, i_interface_strap;
  serial_pins_type i_serial;
  logic [11:0]     i_sample, o_data, cap_word, s, a, b, c, prev_data;
  logic            o_data_oe, o_output_clock, o_clock_oe, cap_valid, prev_oclk;
  analog_cfg_type  o_analog;
  logic [11:0]     q[$];
  int              n_fail, n_checks, rises, hits;
  int              seed = 32'hCDBA28FA;

  adc_output_path i_adc_output_path (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_serial(i_serial),
    .i_format_strap(i_format_strap), .i_interface_strap(i_interface_strap), .i_sample(i_sample),
    .o_data(o_data), .o_data_oe(o_data_oe), .o_output_clock(o_output_clock), .o_clock_oe(o_clock_oe),
    .o_analog(o_analog));
  capture_model i_capture_model (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_data(o_data),
    .i_data_oe(o_data_oe), .i_output_clock(o_output_clock), .i_clock_oe(o_clock_oe),
    .o_word(cap_word), .o_word_valid(cap_valid));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // four core clocks per serial level, above the three the pin sampler needs
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] word;
    word = {addr, data};
    i_serial.sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      i_serial.sdata = word[i];
      tick(4);
      i_serial.sclk = 1'b1;
      tick(4);
      i_serial.sclk = 1'b0;
    end
    tick(4);
    i_serial.sen_n = 1'b1;
    i_serial.sdata = ~word[0];
    tick(6);
  endtask
  task automatic expect_word(input logic [11:0] v);
    q.push_back(v);
    for (int i = 0; i < 40 && q.size() > 0; i++) tick(1);
    if (q.size() > 0) begin
      check("capture wait", 1, 0);
      q.delete();
    end
  endtask
  task automatic grab(output logic [11:0] w);
    for (int i = 0; i < 40 && cap_valid !== 1'b1; i++) tick(1);
    w = cap_word;
    tick(1);
  endtask

  // oldest note against each captured word
  always @(posedge i_core_clk) begin
    if (cap_valid === 1'b1 && q.size() > 0)
      check("o_data", cap_word, q.pop_front());
  end
  // counts clock rises that land on the same edge as a data change
  always @(posedge i_core_clk) begin
    if (o_output_clock === 1'b1 && prev_oclk === 1'b0) begin
      rises++;
      if (o_data !== prev_data) hits++;
    end
    prev_oclk <= o_output_clock;
    prev_data <= o_data;
  end

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // about eight times the expected run length
  initial begin
    #(20 * 40000);
    n_fail++;
    summarize();
  end

  initial begin
    i_rst = 1'b1;
    i_serial = '{1'b1, 1'b0, 1'b0};
    i_format_strap = 1'b0;
    i_interface_strap = 1'b0;
    s = $random(seed);
    i_sample = s;
    tick(4);
    i_rst = 1'b0;
    tick(4);
    check("ddr_mode", o_analog.ddr_mode, 1);
    check("perf_boost_a", o_analog.perf_boost_a, 0);
    expect_word(s);
    wr(8'h42, 8'h08);
    wr(8'h3F, 8'hA5);
    wr(8'h40, 8'h30);
    expect_word(s);
    wr(8'h25, 8'h01);
    expect_word(12'h000);
    wr(8'h25, 8'h02);
    expect_word(12'hFFF);
    wr(8'h25, 8'h05);
    expect_word(12'hA53);
    wr(8'h3D, 8'h80);
    expect_word(12'h253);
    wr(8'h3D, 8'hC0);
    expect_word(12'hA53);
    wr(8'h3D, 8'h00);
    i_format_strap = 1'b1;
    // strap crosses two flops, then a word and a capture must pass before the old word is gone
    tick(8);
    expect_word(12'h253);
    i_format_strap = 1'b0;
    // 6 dB is about twice the distance from mid-code: -16 codes become -32
    i_sample = 12'h7F0;
    wr(8'h25, 8'hC0);
    expect_word(12'h7E0);
    s = $random(seed);
    i_sample = s;
    wr(8'h25, 8'hC8);
    expect_word(s);
    wr(8'h42, 8'h00);
    wr(8'h25, 8'hC5);
    expect_word(s);
    wr(8'h42, 8'h08);
    wr(8'h25, 8'h03);
    grab(a);
    grab(b);
    check("toggle pair", a ^ b, 12'hFFF);
    check("toggle word", (a === 12'h555) || (a === 12'hAAA), 1);
    rises = 0;
    hits = 0;
    tick(20);
    check("default rise", hits, 0);
    wr(8'h41, 8'h4C);
    rises = 0;
    hits = 0;
    tick(20);
    check("aligned rise", hits, rises);
    check("rise seen", rises > 0, 1);
    check("rise amount", {o_analog.rise_shift_enable, o_analog.rise_shift_amount}, 3'h6);
    wr(8'h41, 8'hC1);
    check("parallel", o_analog.ddr_mode, 0);
    check("fall enable", o_analog.fall_shift_enable, 1);
    wr(8'h25, 8'h04);
    grab(a);
    grab(b);
    grab(c);
    check("ramp step", 12'(c - a), 1);
    wr(8'h26, 8'h03);
    wr(8'h03, 8'h03);
    wr(8'h4A, 8'h01);
    wr(8'h43, 8'h03);
    wr(8'h42, 8'h48);
    check("drive", {o_analog.clock_driver_drive, o_analog.data_driver_drive}, 2'h3);
    check("boost a", o_analog.perf_boost_a, 1);
    check("boost b", o_analog.perf_boost_b, 1);
    check("swing", o_analog.swing_override, 1);
    check("fall amount", o_analog.fall_shift_amount, 1);
    wr(8'h43, 8'h10);
    check("driver off", {o_data_oe, o_clock_oe, o_data}, 0);
    wr(8'h43, 8'h00);
    wr(8'h42, 8'h0C);
    check("standby", {o_data_oe, o_clock_oe, o_analog.quick_sleep}, 1);
    wr(8'h42, 8'h08);
    wr(8'h43, 8'h40);
    check("full sleep", {o_data_oe, o_clock_oe, o_analog.full_sleep}, 1);
    wr(8'h43, 8'h00);
    check("awake", {o_data_oe, o_clock_oe}, 2'h3);
    wr(8'h25, 8'h01);
    wr(8'h77, 8'h05);
    expect_word(12'h000);
    wr(8'h00, 8'h02);
    check("soft reset", {o_analog.perf_boost_b, o_analog.ddr_mode}, 1);
    expect_word(s);
    // hold set before enabling keeps the cleared estimate, so samples pass unchanged
    wr(8'h42, 8'h08);
    wr(8'hCF, 8'h80);
    wr(8'h3D, 8'h20);
    expect_word(s);
    summarize();
  end
endmodule
